// ===== ddsl_params.svh
// timing counts, field positions and reset values of the dual dac serial loader
`ifndef DDSL_PARAMS_SVH
`define DDSL_PARAMS_SVH
`define DDSL_FRAME_BITS 16
`define DDSL_BIT_CHAN 15
`define DDSL_BIT_BUF 14
`define DDSL_BIT_MODE_HI 13
`define DDSL_BIT_MODE_LO 12
`define DDSL_CODE_MSB 11
`define DDSL_CODE_W 12
`define DDSL_RST_CODE 12'h000
`define DDSL_RST_MODE 2'h0
`define DDSL_RST_BUF 1'h0
`define DDSL_CLK_PERIOD_NS 4
`define DDSL_SYNC_STAGES 2
`endif

// ===== ddsl_pkg.sv
// types shared by the dual dac serial loader
`default_nettype none
package ddsl_pkg;
    typedef enum logic [1:0] {
        DDSL_PWR_NORMAL = 2'h0,
        DDSL_PWR_DOWN_1K = 2'h1,
        DDSL_PWR_DOWN_100K = 2'h2,
        DDSL_PWR_DOWN_HIZ = 2'h3
    } ddsl_pwr_mode_t;
    typedef struct packed {
        logic [11:0] code;
        logic [1:0] mode;
        logic buffered;
    } ddsl_chan_cfg_t;
    typedef struct packed {
        logic load_outputs_n;
        logic power_mode_hi;
        logic power_mode_lo;
    } ddsl_unused_t;
endpackage
`default_nettype wire

// ===== ddsl_sync2.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module ddsl_sync2 #(
    parameter int W = 3
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // reset every stage to zero; ddsl_top inverts sync and load so that reads as both high, clock low
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== ddsl_top.sv
// serial front end of a dual channel dac: shift register, input and dac registers
// Function
// - sixteen bit shift register, one word per frame
// - sample data on sixteen falling clock edges
// - msb first; bit 15 picks channel
// - bit 14 buffered reference, default unbuffered
// - bits 13:12 mode, default zero
// - code follows control bits, narrow variants truncate
// - code is straight binary
// - bits taken only while frame select low
// - ignore edges after sixteenth until reselect
// - full frame loads addressed input register
// - early frame select rise abandons frame
// - load strobe updates both channels together
// - reset clears registers, normal, unbuffered
// - mode decode: normal, 1k, 100k, hiz
// - dac registers transparent while strobe low
// - dac register updates only after new write
// - power down leaves register contents alone
`include "ddsl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddsl_top #(
    parameter int CODE_BITS = 12
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic load_outputs_n,
    output logic [11:0] dac_code_a,
    output logic [11:0] dac_code_b,
    output logic [1:0] power_mode_a,
    output logic [1:0] power_mode_b,
    output logic ref_buffered_a,
    output logic ref_buffered_b,
    output logic [11:0] input_code_a,
    output logic [11:0] input_code_b,
    output logic frame_done
);
    // ==========================================================
    // pin synchronisers
    logic [3:0] pins_s;
    logic sel_n_s;
    logic sclk_s;
    logic din_s;
    logic ldn_s;

    ddsl_sync2 #(.W(4)) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .async_in({~frame_sel_n, sclk, sdin, ~load_outputs_n}),
        .sync_out(pins_s)
    );

    // inverted active-low pins so the reset value zero means idle
    always_comb
    begin
        sel_n_s = ~pins_s[3];
        sclk_s = pins_s[2];
        din_s = pins_s[1];
        ldn_s = ~pins_s[0];
    end

    // ==========================================================
    // serial shifter
    logic sclk_prev_q, sclk_prev_d;
    logic [15:0] shift_q, shift_d;
    logic [4:0] cnt_q, cnt_d;
    logic lock_q, lock_d;
    logic done_q, done_d;
    logic fall;

    always_comb
    begin
        fall = sclk_prev_q & ~sclk_s;
        sclk_prev_d = sclk_s;
        shift_d = shift_q;
        cnt_d = cnt_q;
        lock_d = lock_q;
        done_d = 1'b0;
        if (sel_n_s)
        begin
            cnt_d = 5'h00;
            lock_d = 1'b0;
        end
        else if (fall && !lock_q)
        begin
            shift_d = {shift_q[14:0], din_s};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(`DDSL_FRAME_BITS - 1))
            begin
                lock_d = 1'b1;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_prev_q <= 1'b0;
            shift_q <= 16'h0000;
            cnt_q <= 5'h00;
            lock_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_prev_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            lock_q <= lock_d;
            done_q <= done_d;
        end
    end

    // ==========================================================
    // input and dac registers per channel
    ddsl_pkg::ddsl_chan_cfg_t in_q [2], in_d [2];
    logic [11:0] dac_q [2], dac_d [2];
    logic [1:0] pend_q, pend_d;
    logic [11:0] code_mask;
    logic [11:0] new_code;

    // narrower parts drop trailing code bits
    always_comb
    begin
        code_mask = 12'hfff << (`DDSL_CODE_W - CODE_BITS);
        new_code = shift_q[`DDSL_CODE_MSB:0] & code_mask;
    end

    // only a completed frame reaches here; abort writes nothing
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            in_d[c] = in_q[c];
            dac_d[c] = dac_q[c];
            pend_d[c] = pend_q[c];
            if (!ldn_s && pend_q[c])
            begin
                dac_d[c] = in_q[c].code;
                pend_d[c] = 1'b0;
            end
            if (done_q && (shift_q[`DDSL_BIT_CHAN] == c[0]))
            begin
                in_d[c].code = new_code;
                in_d[c].buffered = shift_q[`DDSL_BIT_BUF];
                in_d[c].mode = shift_q[`DDSL_BIT_MODE_HI:`DDSL_BIT_MODE_LO];
                pend_d[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int c = 0; c < 2; c++)
            begin
                in_q[c] <= '{code: `DDSL_RST_CODE, mode: `DDSL_RST_MODE,
                             buffered: `DDSL_RST_BUF};
                dac_q[c] <= `DDSL_RST_CODE;
            end
            pend_q <= 2'h0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                in_q[c] <= in_d[c];
                dac_q[c] <= dac_d[c];
            end
            pend_q <= pend_d;
        end
    end

    // ==========================================================
    // registered outputs
    // mode goes out raw; codes kept in power down
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dac_code_a <= 12'h000;
            dac_code_b <= 12'h000;
            power_mode_a <= 2'h0;
            power_mode_b <= 2'h0;
            ref_buffered_a <= 1'b0;
            ref_buffered_b <= 1'b0;
            input_code_a <= 12'h000;
            input_code_b <= 12'h000;
            frame_done <= 1'b0;
        end
        else
        begin
            dac_code_a <= dac_q[0];
            dac_code_b <= dac_q[1];
            power_mode_a <= in_q[0].mode;
            power_mode_b <= in_q[1].mode;
            ref_buffered_a <= in_q[0].buffered;
            ref_buffered_b <= in_q[1].buffered;
            input_code_a <= in_q[0].code;
            input_code_b <= in_q[1].code;
            frame_done <= done_q;
        end
    end

    // ==========================================================
    // checks
    sequence s_full_frame;
        done_q;
    endsequence

    chk_count_cleared: assert property (@(posedge mclk) disable iff (!arst_n)
        sel_n_s |=> (cnt_q == 5'h00) && !lock_q)
        else $error("counter not cleared while deselected");
    chk_no_shift_locked: assert property (@(posedge mclk) disable iff (!arst_n)
        (lock_q && !sel_n_s) |=> $stable(shift_q))
        else $error("shift after sixteenth edge");
    chk_done_at_16: assert property (@(posedge mclk) disable iff (!arst_n)
        done_q |-> $past(cnt_q) == 5'd15)
        else $error("frame completed at wrong count");
    chk_idle_no_shift: assert property (@(posedge mclk) disable iff (!arst_n)
        sel_n_s |=> $stable(shift_q))
        else $error("shift while deselected");
    chk_load_chan_a: assert property (@(posedge mclk) disable iff (!arst_n)
        s_full_frame ##0 !shift_q[15] |=> in_q[0].code == $past(new_code)
        && $stable(in_q[1]))
        else $error("channel a load wrong");
    chk_buf_bit: assert property (@(posedge mclk) disable iff (!arst_n)
        s_full_frame ##0 shift_q[15] |=> in_q[1].buffered == $past(shift_q[14]))
        else $error("buffer bit not stored");
    chk_no_write_abort: assert property (@(posedge mclk) disable iff (!arst_n)
        !done_q |=> $stable(in_q[0]) && $stable(in_q[1]))
        else $error("input register changed without frame");
    chk_dac_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        ldn_s |=> $stable(dac_q[0]) && $stable(dac_q[1]))
        else $error("dac register moved while latched");
    chk_dac_follow: assert property (@(posedge mclk) disable iff (!arst_n)
        (!ldn_s && pend_q[0]) |=> dac_q[0] == $past(in_q[0].code))
        else $error("dac a not updated on load");
    chk_pend_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        !pend_q[1] |=> $stable(dac_q[1]))
        else $error("dac b updated without new write");
endmodule
`default_nettype wire

// ===== ddsl_host_model.sv
// behavioural host that writes frames over the three-wire link
`timescale 1ns/1ps
`default_nettype none
module ddsl_host_model (
    input wire logic mclk,
    output logic frame_sel_n,
    output logic sclk,
    output logic sdin
);
    // half of the 80 ns link clock period, counted in mclk cycles
    localparam int HALF = 10;
    initial
    begin
        frame_sel_n = 1'b1;
        sclk = 1'b1;
        sdin = 1'b0;
    end
    // =====================================================
    // frame writer
    // link clock stands still high between frames
    task automatic send(input logic [31:0] word, input int nbits);
        @(posedge mclk);
        frame_sel_n <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sdin <= word[i];
            repeat (HALF) @(posedge mclk);
            sclk <= 1'b0;
            repeat (HALF) @(posedge mclk);
            sclk <= 1'b1;
        end
        repeat (HALF) @(posedge mclk);
        frame_sel_n <= 1'b1;
        sdin <= ~sdin;
        repeat (HALF) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ===== ddsl_top_tb.sv
// self-checking bench for the dual dac serial loader
`timescale 1ns/1ps
`default_nettype none
module ddsl_top_tb;
    typedef struct packed {
        logic [15:0] word;
        ddsl_pkg::ddsl_chan_cfg_t exp;
    } ddsl_row_t;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic load_outputs_n = 1'b1;
    logic frame_sel_n;
    logic sclk;
    logic sdin;
    logic [11:0] dac_code_a;
    logic [11:0] dac_code_b;
    logic [1:0] power_mode_a;
    logic [1:0] power_mode_b;
    logic ref_buffered_a;
    logic ref_buffered_b;
    logic [11:0] input_code_a;
    logic [11:0] input_code_b;
    logic frame_done;
    logic [11:0] narrow_code_a;
    int fails = 0;
    int n_compared = 0;
    int n_done = 0;
    int done_exp = 0;
    ddsl_pkg::ddsl_chan_cfg_t sh_a = '0;
    ddsl_pkg::ddsl_chan_cfg_t sh_b = '0;
    ddsl_row_t rows [5] = '{
        '{16'h0abc, '{12'habc, 2'h0, 1'h0}},
        '{16'hd123, '{12'h123, 2'h1, 1'h1}},
        '{16'h2fff, '{12'hfff, 2'h2, 1'h0}},
        '{16'hb5a5, '{12'h5a5, 2'h3, 1'h0}},
        '{16'h7800, '{12'h800, 2'h3, 1'h1}}
    };
    always #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (frame_done === 1'b1)
            n_done++;
    end
    ddsl_top u_dut (
        .mclk(mclk), .arst_n(arst_n), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .sdin(sdin), .load_outputs_n(load_outputs_n), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b), .power_mode_a(power_mode_a),
        .power_mode_b(power_mode_b), .ref_buffered_a(ref_buffered_a),
        .ref_buffered_b(ref_buffered_b), .input_code_a(input_code_a),
        .input_code_b(input_code_b), .frame_done(frame_done)
    );
    // ten bit variant on the same link: its two trailing code bits must read zero
    ddsl_top #(.CODE_BITS(10)) u_dut_narrow (
        .mclk(mclk), .arst_n(arst_n), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .sdin(sdin), .load_outputs_n(load_outputs_n), .dac_code_a(),
        .dac_code_b(), .power_mode_a(), .power_mode_b(), .ref_buffered_a(),
        .ref_buffered_b(), .input_code_a(narrow_code_a), .input_code_b(),
        .frame_done()
    );
    ddsl_host_model u_host (
        .mclk(mclk), .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin)
    );
    // =====================================================
    // compare and verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_all();
        chk("channel a", sh_a, {input_code_a, power_mode_a, ref_buffered_a});
        chk("channel b", sh_b, {input_code_b, power_mode_b, ref_buffered_b});
        chk("frame done count", done_exp, n_done);
    endtask
    task automatic check_dac(input logic [11:0] ea, input logic [11:0] eb);
        chk("dac a", ea, dac_code_a);
        chk("dac b", eb, dac_code_b);
    endtask
    task automatic test_done();
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // =====================================================
    // watchdog, well beyond the ten frames of the run
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done();
    end
    // =====================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check_all();
        check_dac(12'h000, 12'h000);
        for (int r = 0; r < 5; r++)
        begin
            u_host.send({16'h0000, rows[r].word}, 16);
            done_exp++;
            if (rows[r].word[15])
                sh_b = rows[r].exp;
            else
                sh_a = rows[r].exp;
            check_all();
        end
        check_dac(12'h000, 12'h000);
        // short frame is dropped, the next full one is taken afresh
        u_host.send(32'h0000_1234, 15);
        check_all();
        u_host.send(32'h0000_1557, 18);
        done_exp++;
        sh_a = {12'h555, 2'h0, 1'h0};
        check_all();
        chk("narrow code a", 12'h554, narrow_code_a);
        @(posedge mclk);
        load_outputs_n <= 1'b0;
        repeat (8) @(posedge mclk);
        check_dac(12'h555, 12'h5a5);
        // strobe held low: a new write flows straight through
        u_host.send(32'h0000_8321, 16);
        done_exp++;
        sh_b = {12'h321, 2'h0, 1'h0};
        check_all();
        check_dac(12'h555, 12'h321);
        load_outputs_n <= 1'b1;
        u_host.send(32'h0000_3777, 16);
        done_exp++;
        sh_a = {12'h777, 2'h3, 1'h0};
        check_all();
        check_dac(12'h555, 12'h321);
        load_outputs_n <= 1'b0;
        repeat (8) @(posedge mclk);
        load_outputs_n <= 1'b1;
        check_dac(12'h777, 12'h321);
        // reset in mid run clears everything again
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        sh_a = '0;
        sh_b = '0;
        check_all();
        check_dac(12'h000, 12'h000);
        // release again: the first frame after reset must be taken afresh
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        u_host.send(32'h0000_9abc, 16);
        done_exp++;
        sh_b = {12'habc, 2'h1, 1'h0};
        check_all();
        test_done();
    end
endmodule
`default_nettype wire
